// [core/tdrq_pkg.sv]
// Constants and types for the transmit descriptor reference queue pointer bank
//
// Overview of operation
// [R1] Free end field: bits 17..2, plus base
// [R2] Ready start at 0x328: bits 17..2, plus base
// [R3] Ready write at 0x32C: bits 17..2, plus base
// [R4] Ready read at 0x330: bits 17..2, plus base
// [R5] Ready end at 0x334: bits 17..2, plus base
// [R6] Any write updates every register bit; status writes only clear the flags written as one
// [R7] All byte lanes off: no access
// [R8] Host spaces write/read pointer writes 4 clocks
// [R9] Host initialises all pointers before transmit use
// [R10] Host writes queue base dword aligned
// [R11] Fields reset zero; upper bits ignored
package tdrq_pkg;

  // Register byte offsets, low address bits decoded
  localparam int unsigned DEC_W = 12;
  localparam logic [11:0] OFS_FREE_END    = 12'h324;
  localparam logic [11:0] OFS_READY_START = 12'h328;
  localparam logic [11:0] OFS_READY_WRITE = 12'h32c;
  localparam logic [11:0] OFS_READY_READ  = 12'h330;
  localparam logic [11:0] OFS_READY_END   = 12'h334;
  localparam logic [11:0] OFS_STATUS      = 12'h338;

  // Pointer field layout
  localparam int unsigned FIELD_W   = 16;
  localparam int unsigned FIELD_LSB = 2;
  localparam int unsigned NUM_PTR   = 5;
  localparam logic [15:0] FIELD_RST = 16'h0000;

  // Status register bit positions
  localparam int unsigned ST_WR_SPACING = 0;
  localparam int unsigned ST_RD_SPACING = 1;
  localparam int unsigned ST_ALL_INIT   = 2;
  localparam logic [2:0]  STATUS_RST    = 3'h0;

  // Least spacing of pointer writes, in clock periods
  localparam logic [2:0] WR_SPACING = 3'h4;
  localparam logic [2:0] AGE_MAX    = 3'h7;

  // Byte lane enables all negated
  localparam logic [3:0] LANES_OFF = 4'hf;

  // Register selector, pointer entries index the pointer array
  typedef enum logic [2:0] {
    SEL_FREE_END    = 3'h0,
    SEL_READY_START = 3'h1,
    SEL_READY_WRITE = 3'h2,
    SEL_READY_READ  = 3'h3,
    SEL_READY_END   = 3'h4,
    SEL_STATUS      = 3'h5,
    SEL_NONE        = 3'h7
  } tdrq_sel_type;

endpackage

// [core/tdrq_addr_calc.sv]
// Physical queue address from a pointer field and the queue base
`timescale 1ns/100ps
`default_nettype none
module tdrq_addr_calc #(
  parameter int unsigned FIELD_W = 16,
  parameter int unsigned ADDR_W  = 32
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // Operands
  input  wire logic [FIELD_W-1:0]  field_i,
  input  wire logic [ADDR_W-1:0]   base_i,
  // Registered physical address
  output logic      [ADDR_W-1:0]   phys_q
);
  import tdrq_pkg::*;

  // Field widened and shifted to dword address bits
  logic [ADDR_W-1:0] offset;
  assign offset = ADDR_W'({field_i, 2'b00});

  // Sum registered, wraps modulo the address width
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phys_q <= '0;
    end
    else
    begin
      phys_q <= base_i + offset; // [R1]
    end
  end

  // Address follows field and base one cycle later, not in the first cycle out of reset
  phys_sum_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    $past(hresetn) |-> phys_q == $past(base_i) + ADDR_W'({$past(field_i), 2'b00}))
    else $error("physical address not base plus field shifted by two");

endmodule
`default_nettype wire

// [core/tdrq_regs.sv]
// AHB-Lite register bank for transmit descriptor reference queue pointers
`timescale 1ns/100ps
`default_nettype none
module tdrq_regs #(
  parameter int unsigned ADDR_W = 32
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave, address phase
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  // AHB-Lite slave, data phase
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Byte lane enables, active low, with the address phase
  input  wire logic [3:0]        byte_lane_enables_n,
  // Queue base held elsewhere
  input  wire logic [ADDR_W-1:0] transmit_queue_base,
  // Physical queue addresses
  output logic      [ADDR_W-1:0] free_end_addr,
  output logic      [ADDR_W-1:0] ready_start_addr,
  output logic      [ADDR_W-1:0] ready_write_addr,
  output logic      [ADDR_W-1:0] ready_read_addr,
  output logic      [ADDR_W-1:0] ready_end_addr,
  // All pointers written since reset
  output logic                   pointers_initialised
);
  import tdrq_pkg::*;

  // Pointer fields, indexed by selector
  logic [FIELD_W-1:0] ptr_q [NUM_PTR];
  logic [FIELD_W-1:0] ptr_d [NUM_PTR];
  // Sticky status and written-since-reset marks
  logic [2:0]         status_q;
  logic [2:0]         status_d;
  logic [NUM_PTR-1:0] written_q;
  // Data phase bookkeeping
  logic               wr_pend_q;
  tdrq_sel_type       wr_sel_q;
  // Cycles since last write to ready write / read pointer
  logic [2:0]         age_wr_q;
  logic [2:0]         age_rd_q;
  // Read data and initialised flag flops
  logic [31:0]        hrdata_q;
  logic               init_q;

  // Address phase decode
  logic               addr_ok;
  logic               lanes_on;
  tdrq_sel_type       sel;
  logic               wr_take;
  logic               rd_take;

  assign addr_ok  = hsel && htrans[1] && hready;
  assign lanes_on = (byte_lane_enables_n != LANES_OFF); // [R7]
  assign wr_take  = addr_ok && hwrite && lanes_on; // [R7]
  assign rd_take  = addr_ok && !hwrite && lanes_on; // [R7]

  // Offset to selector; unmapped offsets select nothing
  always_comb
  begin
    case (haddr[DEC_W-1:0])
      OFS_FREE_END:    sel = SEL_FREE_END;
      OFS_READY_START: sel = SEL_READY_START;
      OFS_READY_WRITE: sel = SEL_READY_WRITE;
      OFS_READY_READ:  sel = SEL_READY_READ;
      OFS_READY_END:   sel = SEL_READY_END;
      OFS_STATUS:      sel = SEL_STATUS;
      default:         sel = SEL_NONE;
    endcase
  end

  // Write strobe for a selector in the current data phase
  function automatic logic wr_hit(input logic pend, input tdrq_sel_type s, input tdrq_sel_type want);
    wr_hit = pend && (s == want);
  endfunction

  // Next pointer values; whole field taken whatever the size
  always_comb
  begin
    for (int i = 0; i < NUM_PTR; i++)
    begin
      ptr_d[i] = ptr_q[i];
      if (wr_pend_q && (wr_sel_q == tdrq_sel_type'(i[2:0])))
      begin
        ptr_d[i] = hwdata[FIELD_W-1:0]; // [R6] [R11]
      end
    end
  end

  // Next status: spacing faults set, one written clears, set wins
  always_comb
  begin
    status_d = status_q;
    if (wr_hit(wr_pend_q, wr_sel_q, SEL_STATUS))
    begin
      status_d[ST_WR_SPACING] = status_q[ST_WR_SPACING] & ~hwdata[ST_WR_SPACING];
      status_d[ST_RD_SPACING] = status_q[ST_RD_SPACING] & ~hwdata[ST_RD_SPACING];
    end
    // Too close a second write to the ready write pointer
    if (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_WRITE) && (age_wr_q < WR_SPACING - 3'h1))
    begin
      status_d[ST_WR_SPACING] = 1'b1; // [R8]
    end
    // Too close a second write to the ready read pointer
    if (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_READ) && (age_rd_q < WR_SPACING - 3'h1))
    begin
      status_d[ST_RD_SPACING] = 1'b1; // [R8]
    end
    status_d[ST_ALL_INIT] = &written_q;
  end

  // Pointer registers, zero after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_PTR; i++)
      begin
        ptr_q[i] <= FIELD_RST; // [R11]
      end
    end
    else
    begin
      for (int i = 0; i < NUM_PTR; i++)
      begin
        ptr_q[i] <= ptr_d[i]; // [R2] [R3] [R4] [R5]
      end
    end
  end

  // Marks of pointers written since reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      written_q <= '0;
    end
    else if (wr_pend_q && (wr_sel_q != SEL_STATUS) && (wr_sel_q != SEL_NONE))
    begin
      written_q[wr_sel_q] <= 1'b1; // [R9]
    end
  end

  // Status register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= STATUS_RST;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // Spacing age counters, saturate at their top
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      age_wr_q <= AGE_MAX;
      age_rd_q <= AGE_MAX;
    end
    else
    begin
      // Restart on each write, else count up
      if (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_WRITE))
        age_wr_q <= 3'h0;
      else if (age_wr_q != AGE_MAX)
        age_wr_q <= age_wr_q + 3'h1;
      if (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_READ))
        age_rd_q <= 3'h0;
      else if (age_rd_q != AGE_MAX)
        age_rd_q <= age_rd_q + 3'h1;
    end
  end

  // Address phase capture of a write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_sel_q  <= SEL_NONE;
    end
    else
    begin
      wr_pend_q <= wr_take && (sel != SEL_NONE);
      wr_sel_q  <= sel;
    end
  end

  // Read data, taken from next values so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      case (sel)
        SEL_FREE_END,
        SEL_READY_START,
        SEL_READY_WRITE,
        SEL_READY_READ,
        SEL_READY_END: hrdata_q <= {16'h0000, ptr_d[sel]}; // [R11]
        SEL_STATUS:    hrdata_q <= {29'h0000_0000, status_d};
        default:       hrdata_q <= 32'h0000_0000;
      endcase
    end
    else
    begin
      // No read or lanes off: nothing is read
      hrdata_q <= 32'h0000_0000; // [R7]
    end
  end

  // Initialised flag out of a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_q <= 1'b0;
    end
    else
    begin
      init_q <= status_d[ST_ALL_INIT];
    end
  end

  // Zero wait states, always OKAY, both held in flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata               = hrdata_q;
  assign pointers_initialised = init_q;

  // One address unit per pointer
  tdrq_addr_calc #(.FIELD_W(FIELD_W), .ADDR_W(ADDR_W)) u_free_end (
    .hclk    (hclk),
    .hresetn (hresetn),
    .field_i (ptr_q[SEL_FREE_END]),
    .base_i  (transmit_queue_base),
    .phys_q  (free_end_addr)
  ); // [R1]
  tdrq_addr_calc #(.FIELD_W(FIELD_W), .ADDR_W(ADDR_W)) u_ready_start (
    .hclk    (hclk),
    .hresetn (hresetn),
    .field_i (ptr_q[SEL_READY_START]),
    .base_i  (transmit_queue_base),
    .phys_q  (ready_start_addr)
  ); // [R2]
  tdrq_addr_calc #(.FIELD_W(FIELD_W), .ADDR_W(ADDR_W)) u_ready_write (
    .hclk    (hclk),
    .hresetn (hresetn),
    .field_i (ptr_q[SEL_READY_WRITE]),
    .base_i  (transmit_queue_base),
    .phys_q  (ready_write_addr)
  ); // [R3]
  tdrq_addr_calc #(.FIELD_W(FIELD_W), .ADDR_W(ADDR_W)) u_ready_read (
    .hclk    (hclk),
    .hresetn (hresetn),
    .field_i (ptr_q[SEL_READY_READ]),
    .base_i  (transmit_queue_base),
    .phys_q  (ready_read_addr)
  ); // [R4]
  tdrq_addr_calc #(.FIELD_W(FIELD_W), .ADDR_W(ADDR_W)) u_ready_end (
    .hclk    (hclk),
    .hresetn (hresetn),
    .field_i (ptr_q[SEL_READY_END]),
    .base_i  (transmit_queue_base),
    .phys_q  (ready_end_addr)
  ); // [R5]

  // Checks on bus effects
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Whole pointer view: no write, no change
  logic [FIELD_W*NUM_PTR-1:0] all_ptr;
  assign all_ptr = {ptr_q[0], ptr_q[1], ptr_q[2], ptr_q[3], ptr_q[4]};
  ptr_hold_a: assert property (!wr_pend_q |=> $stable(all_ptr)) // [R7]
    else $error("pointer changed without a write");

  free_end_wr_a: assert property ( // [R1]
    (wr_take && sel == SEL_FREE_END) |=> ##1 ptr_q[SEL_FREE_END] == $past(hwdata[15:0]))
    else $error("free end field not written");
  start_wr_a: assert property ( // [R2]
    (wr_take && sel == SEL_READY_START) ##1 1'b1 |=> ptr_q[SEL_READY_START] == $past(hwdata[15:0]))
    else $error("ready start field not written");
  write_ptr_addr_a: assert property ( // [R3]
    (wr_take && sel == SEL_READY_WRITE) |-> ##3
      ready_write_addr == $past(transmit_queue_base) + {14'h0000, $past(hwdata[15:0], 2), 2'b00})
    else $error("ready write address wrong after write");
  read_ptr_wr_a: assert property ( // [R4]
    wr_hit(wr_pend_q, wr_sel_q, SEL_READY_READ) |=> ptr_q[SEL_READY_READ] == $past(hwdata[15:0]))
    else $error("ready read field not written");
  end_rd_back_a: assert property ( // [R5]
    (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_END) ##1 !wr_pend_q ##1 (!wr_pend_q && rd_take && sel == SEL_READY_END))
      |=> hrdata[15:0] == $past(hwdata[15:0], 3))
    else $error("ready end read did not return the write");
  narrow_wr_a: assert property ( // [R6]
    (wr_take && sel == SEL_READY_START && byte_lane_enables_n != 4'h0) |=> ##1
      ptr_q[SEL_READY_START] == $past(hwdata[15:0]))
    else $error("partial lane write did not update whole field");
  lanes_off_a: assert property ( // [R7]
    (addr_ok && (byte_lane_enables_n == LANES_OFF)) |=> (!wr_pend_q && hrdata == 32'h0000_0000))
    else $error("access made with all byte lanes off");
  upper_zero_a: assert property ( // [R11]
    hrdata[31:16] == 16'h0000 && hreadyout && !hresp)
    else $error("upper bits or response wrong");
  spacing_flag_a: assert property ( // [R8]
    (wr_hit(wr_pend_q, wr_sel_q, SEL_READY_WRITE) && age_wr_q < 3'h3) |=> status_q[ST_WR_SPACING])
    else $error("close writes not flagged");

  // Main scenarios
  cov_write_read_c: cover property ((wr_take && sel == SEL_READY_WRITE) ##3 (rd_take && sel == SEL_READY_WRITE));
  cov_all_init_c:   cover property ($rose(pointers_initialised));
  cov_spacing_c:    cover property ($rose(status_q[ST_RD_SPACING]));
  cov_lanes_off_c:  cover property (addr_ok && hwrite && byte_lane_enables_n == LANES_OFF);

endmodule
`default_nettype wire

// [dv/tx_descriptor_ready_queue_pointers_tb.sv]
// Self-checking testbench for the queue pointer register bank
`timescale 1ns/100ps
`default_nettype none
module tx_descriptor_ready_queue_pointers_tb;
  import tdrq_pkg::*;
  // Clock and reset
  logic        hclk;
  logic        hresetn;
  // Bus side
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic        hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  byte_lane_enables_n;
  // Queue base and physical addresses
  logic [31:0] transmit_queue_base;
  logic [31:0] addr_out [NUM_PTR];
  logic        pointers_initialised;
  // Bench state
  int          errors;
  int          cmp_count;
  int          cycles = 0;
  logic [15:0] lfsr_q;
  logic [15:0] field_q [NUM_PTR];
  logic [31:0] rd;
  logic [31:0] d;
  logic [3:0]  lane_tab [5] = '{4'h0, 4'he, 4'h7, 4'hf, 4'hb};
  logic [11:0] ofs [NUM_PTR] = '{OFS_FREE_END, OFS_READY_START, OFS_READY_WRITE, OFS_READY_READ, OFS_READY_END};

  // Zero wait-state slave drives the bus ready
  assign hready = hreadyout;

  // Device under test
  tdrq_regs dut_u (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hready               (hready),
    .hwdata               (hwdata),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .byte_lane_enables_n  (byte_lane_enables_n),
    .transmit_queue_base  (transmit_queue_base),
    .free_end_addr        (addr_out[0]),
    .ready_start_addr     (addr_out[1]),
    .ready_write_addr     (addr_out[2]),
    .ready_read_addr      (addr_out[3]),
    .ready_end_addr       (addr_out[4]),
    .pointers_initialised (pointers_initialised)
  );

  // Clock generator, 40 ns period
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  // Hang guard
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      summarize();
    end
  end

  // Step the random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected physical address: base plus field on dword address bits
  function automatic logic [31:0] exp_phys(input logic [31:0] base, input logic [15:0] f);
    return base + {14'h0, f, 2'h0};
  endfunction

  // Compare seen against expected
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset pulse of four cycles, expected fields cleared
  task automatic reset_dut();
    @(posedge hclk);
    hresetn <= 1'b0;
    for (int i = 0; i < NUM_PTR; i++)
      field_q[i] = FIELD_RST;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] ln,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel                <= 1'b1;
    haddr               <= {20'h0, a};
    htrans              <= 2'b10;
    hwrite              <= wr;
    byte_lane_enables_n <= ln;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask

  // Physical addresses follow fields and base
  task automatic check_addrs();
    // Outputs read at the edge still show their settled value
    repeat (2) @(posedge hclk);
    for (int i = 0; i < NUM_PTR; i++)
      check("phys address", addr_out[i], exp_phys(transmit_queue_base, field_q[i]));
  endtask

  // Read every pointer back
  task automatic check_fields();
    for (int i = 0; i < NUM_PTR; i++)
    begin
      xfer(1'b0, ofs[i], 32'h0, 4'h0, rd);
      check("pointer field", rd, {16'h0, field_q[i]});
    end
  endtask

  // Main sequence
  initial
  begin
    hresetn             = 1'b0;
    hsel                = 1'b0;
    haddr               = 32'h0;
    htrans              = 2'b00;
    hwrite              = 1'b0;
    hsize               = 3'h2;
    hwdata              = 32'h0;
    byte_lane_enables_n = 4'h0;
    transmit_queue_base = 32'h0;
    lfsr_q              = 16'd24190;
    errors              = 0;
    cmp_count           = 0;
    reset_dut();
    // Reset values
    check_fields();
    check("init flag", {31'h0, pointers_initialised}, 32'h0);
    check_addrs();
    // Rounds of random writes under different lane patterns
    for (int r = 0; r < 5; r++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      transmit_queue_base <= {lfsr_q, lfsr_q[13:0], 2'b00};
      for (int i = 0; i < NUM_PTR; i++)
      begin
        lfsr_q = lfsr_next(lfsr_q);
        d = {~lfsr_q, lfsr_q};
        xfer(1'b1, ofs[i], d, lane_tab[r], rd);
        if (lane_tab[r] != LANES_OFF)
          field_q[i] = d[15:0];
        repeat (4) @(posedge hclk);
      end
      check_fields();
      check_addrs();
      check("init flag", {31'h0, pointers_initialised}, 32'h1);
    end
    // Read with lanes off, unmapped write, unmapped read
    xfer(1'b0, OFS_READY_START, 32'h0, LANES_OFF, rd);
    check("lanes off read", rd, 32'h0);
    xfer(1'b1, 12'h3fc, 32'hffff_ffff, 4'h0, rd);
    xfer(1'b0, 12'h3fc, 32'h0, 4'h0, rd);
    check("unmapped read", rd, 32'h0);
    check_fields();
    xfer(1'b0, OFS_STATUS, 32'h0, 4'h0, rd);
    check("status", rd, 32'h4);
    // Close writes to the write and read pointers, then clear each flag
    xfer(1'b1, OFS_READY_WRITE, 32'h0000_1234, 4'h0, rd);
    xfer(1'b1, OFS_READY_WRITE, 32'h0000_4321, 4'h0, rd);
    xfer(1'b0, OFS_READY_WRITE, 32'h0, 4'h0, rd);
    check("ready write field", rd, 32'h0000_4321);
    xfer(1'b1, OFS_READY_READ, 32'h0000_5678, 4'h0, rd);
    xfer(1'b1, OFS_READY_READ, 32'h0000_8765, 4'h0, rd);
    field_q[2] = 16'h4321;
    field_q[3] = 16'h8765;
    xfer(1'b0, OFS_STATUS, 32'h0, 4'h0, rd);
    check("status", rd, 32'h7);
    xfer(1'b1, OFS_STATUS, 32'h1, 4'h0, rd);
    xfer(1'b0, OFS_STATUS, 32'h0, 4'h0, rd);
    check("status", rd, 32'h6);
    xfer(1'b1, OFS_STATUS, 32'h2, 4'h0, rd);
    xfer(1'b0, OFS_STATUS, 32'h0, 4'h0, rd);
    check("status", rd, 32'h4);
    // Write the ready end field and read it straight back
    xfer(1'b1, OFS_READY_END, 32'hbeef_0abc, 4'h0, rd);
    field_q[4] = 16'h0abc;
    xfer(1'b0, OFS_READY_END, 32'h0, 4'h0, rd);
    check("ready end field", rd, 32'h0000_0abc);
    check_fields();
    check_addrs();
    // Reset in mid-run clears the fields and the init flag
    reset_dut();
    check_fields();
    check("init flag", {31'h0, pointers_initialised}, 32'h0);
    check_addrs();
    summarize();
  end
endmodule
`default_nettype wire
